// ---- logic/sbc_pkg.sv ----
// sbc_pkg: constants, commands and field layout of the burst-interrupt dram core
// assumes: apb register window with 32-bit data, 12 address bits decoded
package sbc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] SBC_CTRL_OFS = 12'h000;
    localparam logic [11:0] SBC_STAT_OFS = 12'h004;

    // ctrl fields
    localparam int SBC_CTRL_CL3_BIT = 0;      // 0: cas latency 2, 1: cas latency 3
    localparam int SBC_CTRL_FULL_BIT = 1;     // full-page burst
    localparam int SBC_CTRL_BL_LSB = 2;       // burst length code, 2 bits
    localparam int SBC_CTRL_SINGLE_BIT = 4;   // burst read, single write
    localparam logic [4:0] SBC_CTRL_RESET = 5'h00;

    // status fields
    localparam int SBC_STAT_BANK_LSB = 0;     // 2 bits, bank active
    localparam int SBC_STAT_WR_BIT = 2;
    localparam int SBC_STAT_RD_BIT = 3;
    localparam int SBC_STAT_SUSP_BIT = 4;

    // ----------------------------------------------------------------
    // pin fields and timing
    // ----------------------------------------------------------------
    localparam int SBC_BANK_SELECT_BIT = 11;
    localparam int SBC_ALL_BANKS_SELECT_BIT = 10;
    localparam int SBC_COL_W = 8;
    localparam int SBC_READ_MASK_LATENCY = 2;  // clocks, both cas latencies
    localparam int SBC_CL_SHORT = 2;
    localparam int SBC_CL_LONG = 3;

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_READ,
        CMD_WRITE,
        CMD_PRE,
        CMD_BST
    } sbc_cmd_t;

endpackage : sbc_pkg

// ---- logic/sbc_mask_delay.sv ----
// sbc_mask_delay: per byte lane delay of the read mask by two clocks
// assumes: mask pins come from controller logic on pclk; hold freezes the line
`timescale 1ns/1ps
`default_nettype none

module sbc_mask_delay
    import sbc_pkg::*;
(
    input wire logic pclk,           // system clock
    input wire logic presetn,        // async reset, active low
    input wire logic hold,           // clock suspend, freeze stages
    input wire logic [1:0] mask_in,  // {upper, lower} byte mask
    output logic [1:0] mask_out      // mask delayed by the read mask latency
);

    // ----------------------------------------------------------------
    // delay line, one per lane
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic [SBC_READ_MASK_LATENCY-1:0] stage_q;
            // shift mask through the stages
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_q <= '0;
                end else if (!hold) begin
                    stage_q <= {stage_q[SBC_READ_MASK_LATENCY-2:0], mask_in[g]};
                end
            end
            assign mask_out[g] = stage_q[SBC_READ_MASK_LATENCY-1];
        end
    endgenerate

endmodule // sbc_mask_delay

`default_nettype wire

// ---- logic/sbc_sdram_core.sv ----
// sbc_sdram_core: two-bank 16-bit sdram data core with burst stop,
// precharge interruption, byte masking and clock suspend
// assumes: command pins are driven by controller logic on pclk; config over apb
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sbc_sdram_core
    import sbc_pkg::*;
(
    input wire logic pclk,              // system clock, 200 mhz
    input wire logic presetn,           // async reset, active low
    input wire logic psel,              // apb select
    input wire logic penable,           // apb access phase
    input wire logic pwrite,            // apb direction
    input wire logic [31:0] paddr,      // apb byte address
    input wire logic [31:0] pwdata,     // apb write data
    output logic [31:0] prdata,         // apb read data
    output logic pready,                // apb ready
    output logic pslverr,               // apb error, unmapped address or status write
    input wire logic clock_gate,        // clock gate, low suspends
    input wire logic cs_n,              // chip select, active low
    input wire logic ras_n,             // row strobe, active low
    input wire logic cas_n,             // column strobe, active low
    input wire logic we_n,              // write enable, active low
    input wire logic [11:0] addr,       // address pins
    input wire logic upper_byte_mask,   // mask for dq 15:8
    input wire logic lower_byte_mask,   // mask for dq 7:0
    input wire logic [15:0] dq_in,      // data pins, input side
    output logic [15:0] dq_out,         // data pins, output side
    output logic [1:0] dq_oe            // per-byte output enable
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // column wrap mask for the burst length, also burst length minus one
    function automatic logic [7:0] wrap_mask(input logic [4:0] ctrl);
        logic [7:0] m;
        m = 8'h00;
        if (ctrl[SBC_CTRL_FULL_BIT]) begin
            m = 8'hff;
        end else begin
            unique case (ctrl[SBC_CTRL_BL_LSB +: 2])
                2'h0: m = 8'h00;
                2'h1: m = 8'h01;
                2'h2: m = 8'h03;
                2'h3: m = 8'h07;
            endcase
        end
        return m;
    endfunction

    // next column within the wrap block
    function automatic logic [7:0] next_col(input logic [7:0] col, input logic [7:0] m);
        logic [7:0] inc;
        inc = col + 8'h01;
        return (col & ~m) | (inc & m);
    endfunction

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    logic [4:0] ctrl_q;
    logic [31:0] status;
    logic apb_hit_ctrl;
    logic apb_hit_stat;
    logic susp_q;
    logic wr_act_q;
    logic rd_act_q;
    logic [1:0] bank_act_q;

    assign apb_hit_ctrl = paddr[11:0] == SBC_CTRL_OFS;
    assign apb_hit_stat = paddr[11:0] == SBC_STAT_OFS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(apb_hit_ctrl || (apb_hit_stat && !pwrite));

    // status word from live state
    always_comb begin
        status = 32'h0000_0000;
        status[SBC_STAT_BANK_LSB +: 2] = bank_act_q;
        status[SBC_STAT_WR_BIT] = wr_act_q;
        status[SBC_STAT_RD_BIT] = rd_act_q;
        status[SBC_STAT_SUSP_BIT] = susp_q;
    end

    // control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= SBC_CTRL_RESET;
        end else if (psel && penable && pwrite && apb_hit_ctrl) begin
            ctrl_q <= pwdata[4:0];
        end
    end

    // read data, zero when unmapped
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_hit_ctrl) begin
            prdata = {27'h0, ctrl_q};
        end else if (apb_hit_stat) begin
            prdata = status;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    sbc_cmd_t cmd;
    logic frz;
    logic sel_bank;
    logic all_banks;
    logic [7:0] col_in;
    logic [7:0] wmask;
    logic [1:0] lane_mask;
    logic cl3;
    logic single;

    assign frz = susp_q;
    assign sel_bank = addr[SBC_BANK_SELECT_BIT];
    assign all_banks = addr[SBC_ALL_BANKS_SELECT_BIT];
    assign col_in = addr[SBC_COL_W-1:0];
    assign wmask = wrap_mask(ctrl_q);
    assign lane_mask = {upper_byte_mask, lower_byte_mask};
    assign cl3 = ctrl_q[SBC_CTRL_CL3_BIT];
    assign single = ctrl_q[SBC_CTRL_SINGLE_BIT];

    always_comb begin
        cmd = CMD_NOP;
        if (!frz && !cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'b011: cmd = CMD_ACT;
                3'b101: cmd = CMD_READ;
                3'b100: cmd = CMD_WRITE;
                3'b010: cmd = CMD_PRE;
                3'b110: cmd = CMD_BST;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clock suspend and bank state
    // ----------------------------------------------------------------
    // enter suspend next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_q <= 1'b0;
        end else if (susp_q) begin
            susp_q <= !clock_gate;
        end else begin
            susp_q <= !clock_gate && (wr_act_q || rd_act_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_act_q <= 2'h0;
        end else if (cmd == CMD_ACT) begin
            bank_act_q[sel_bank] <= 1'b1;
        end else if (cmd == CMD_PRE) begin
            if (all_banks) begin
                bank_act_q <= 2'h0;
            end else begin
                bank_act_q[sel_bank] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // write burst
    // ----------------------------------------------------------------
    logic wr_bank_q;
    logic [7:0] wr_col_q;
    logic [7:0] wr_cnt_q;
    logic pre_hit_wr;
    logic stop_wr;
    logic wr_go;
    logic [8:0] wr_addr;
    logic [1:0] mem_we;

    always_comb begin
        pre_hit_wr = cmd == CMD_PRE && (all_banks || sel_bank == wr_bank_q);
        stop_wr = wr_act_q && (pre_hit_wr || cmd == CMD_BST || cmd == CMD_READ);
        wr_go = cmd == CMD_WRITE || (!frz && wr_act_q && !stop_wr);
        wr_addr = cmd == CMD_WRITE ? {sel_bank, col_in} : {wr_bank_q, wr_col_q};
    end

    assign mem_we = {2{wr_go}} & ~lane_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_act_q <= 1'b0;
            wr_bank_q <= 1'b0;
            wr_col_q <= 8'h00;
            wr_cnt_q <= 8'h00;
        end else if (cmd == CMD_WRITE) begin
            wr_act_q <= wmask != 8'h00 && !single;
            wr_bank_q <= sel_bank;
            wr_col_q <= next_col(col_in, wmask);
            wr_cnt_q <= wmask;
        end else if (stop_wr) begin
            wr_act_q <= 1'b0;
        end else if (wr_go) begin
            wr_col_q <= next_col(wr_col_q, wmask);
            wr_cnt_q <= wr_cnt_q - 8'h01;
            if (!ctrl_q[SBC_CTRL_FULL_BIT] && wr_cnt_q == 8'h01) begin
                wr_act_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read burst
    // ----------------------------------------------------------------
    logic rd_bank_q;
    logic [7:0] rd_col_q;
    logic [7:0] rd_cnt_q;
    logic stop_rd;
    logic rd_go;
    logic [8:0] rd_addr;
    logic [15:0] rd_word;

    // read ends on stop, same-bank precharge or a new column command
    always_comb begin
        stop_rd = rd_act_q && (cmd == CMD_BST || cmd == CMD_WRITE
                  || (cmd == CMD_PRE && (all_banks || sel_bank == rd_bank_q)));
        rd_go = cmd == CMD_READ || (!frz && rd_act_q && !stop_rd);
        rd_addr = cmd == CMD_READ ? {sel_bank, col_in} : {rd_bank_q, rd_col_q};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_act_q <= 1'b0;
            rd_bank_q <= 1'b0;
            rd_col_q <= 8'h00;
            rd_cnt_q <= 8'h00;
        end else if (cmd == CMD_READ) begin
            rd_act_q <= wmask != 8'h00;
            rd_bank_q <= sel_bank;
            rd_col_q <= next_col(col_in, wmask);
            rd_cnt_q <= wmask;
        end else if (stop_rd) begin
            rd_act_q <= 1'b0;
        end else if (rd_go) begin
            rd_col_q <= next_col(rd_col_q, wmask);
            rd_cnt_q <= rd_cnt_q - 8'h01;
            if (!ctrl_q[SBC_CTRL_FULL_BIT] && rd_cnt_q == 8'h01) begin
                rd_act_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // storage, one array per byte lane (rows alias)
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_mem
            logic [7:0] lane_mem [0:511];
            // lane write port
            always_ff @(posedge pclk) begin
                if (mem_we[g]) begin
                    lane_mem[wr_addr] <= dq_in[g*8 +: 8];
                end
            end
            assign rd_word[g*8 +: 8] = lane_mem[rd_addr];
        end
    endgenerate

    // ----------------------------------------------------------------
    // output pipeline, cas latency taps
    // ----------------------------------------------------------------
    logic [2:0] pv_q;
    logic [15:0] pd_q [0:2];
    logic [1:0] mask_d2;
    logic out_valid;

    // issued words drain for cas latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pv_q <= 3'h0;
            pd_q[0] <= 16'h0000;
            pd_q[1] <= 16'h0000;
            pd_q[2] <= 16'h0000;
        end else if (!frz) begin
            pv_q <= {pv_q[1:0], rd_go};
            pd_q[0] <= rd_word;
            pd_q[1] <= pd_q[0];
            pd_q[2] <= pd_q[1];
        end
    end

    sbc_mask_delay u_mask (
        .pclk(pclk),
        .presetn(presetn),
        .hold(frz),
        .mask_in(lane_mask),
        .mask_out(mask_d2)
    );

    assign out_valid = cl3 ? pv_q[2] : pv_q[1];
    assign dq_out = cl3 ? pd_q[2] : pd_q[1];
    assign dq_oe = {2{out_valid}} & ~mask_d2;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_pre_stops_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_act_q && pre_hit_wr && !frz) |-> mem_we == 2'h0)
        else $error("write stored in precharge cycle");

    a_other_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_act_q && cmd == CMD_PRE && !all_banks && sel_bank != wr_bank_q && lane_mask == 2'h0)
        |-> mem_we == 2'h3)
        else $error("other bank precharge broke the write");

    a_full_page_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q[SBC_CTRL_FULL_BIT] && wr_act_q && wr_go && cmd != CMD_WRITE && !stop_wr)
        |=> wr_col_q == $past(wr_col_q) + 8'h01 && wr_act_q)
        else $error("full page column did not step");

    a_read_stop_drain: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_act_q && cmd == CMD_BST && !frz && !cl3 && clock_gate) ##1 clock_gate
        |-> out_valid ##1 !out_valid)
        else $error("read stop drain length wrong");

    a_bst_write_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_act_q && cmd == CMD_BST) |-> mem_we == 2'h0 ##1 !wr_act_q)
        else $error("write continued after burst stop");

    a_read_mask_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        (upper_byte_mask && !frz && clock_gate) ##1 clock_gate |-> ##1 !dq_oe[1])
        else $error("upper lane driven two clocks after mask");

    a_mask_keeps_count: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_act_q && wr_go && !stop_wr && cmd == CMD_NOP && lane_mask == 2'h3)
        |=> wr_col_q == next_col($past(wr_col_q), $past(wmask)))
        else $error("column stalled while masked");

    a_write_lane_drop: assert property (@(posedge pclk) disable iff (!presetn)
        lower_byte_mask |-> !mem_we[0])
        else $error("masked lower lane written");

    a_single_write: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd == CMD_WRITE && single) |-> mem_we == ~lane_mask ##1 !wr_act_q)
        else $error("single write mode burst continued");

    a_suspend_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        (susp_q && cmd == CMD_NOP) |=> $stable(wr_col_q) && $stable(rd_col_q) && $stable(pv_q))
        else $error("state moved in clock suspend");

    a_precharge_all: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd == CMD_PRE && all_banks) |=> bank_act_q == 2'h0)
        else $error("all-bank precharge left a bank active");

endmodule // sbc_sdram_core

`default_nettype wire

// ---- tb/sbc_ctl_model.sv ----
// sbc_ctl_model: behavioural memory controller on the command and data pins
// assumes: the bench calls cmd once per clock; pins change just after rising edges
`timescale 1ns/1ps
`default_nettype none

module sbc_ctl_model
    import sbc_pkg::*;
#(
    parameter int ACT_GAP = 3  // clocks kept around an activate
)
(
    input wire logic pclk,           // system clock
    output logic clock_gate,         // clock gate, low suspends
    output logic cs_n,               // chip select, active low
    output logic ras_n,              // row strobe, active low
    output logic cas_n,              // column strobe, active low
    output logic we_n,               // write enable, active low
    output logic [11:0] addr,        // address pins
    output logic upper_byte_mask,    // mask for dq 15:8
    output logic lower_byte_mask,    // mask for dq 7:0
    output logic [15:0] ctl_dq,      // data driven toward the device
    input wire logic [15:0] dq_out,  // data from the device
    input wire logic [1:0] dq_oe     // device lane enables
);
    // ----------------------------------------------------------------
    // pin drive and capture
    // ----------------------------------------------------------------
    logic [15:0] q_dq;  // device data seen just before the last edge
    logic [1:0] q_oe;  // device enables seen just before the last edge
    logic [1:0] bank_open;

    // idle pins at time zero
    initial begin
        clock_gate = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        addr = 12'h000;
        {upper_byte_mask, lower_byte_mask} = 2'b11;
        ctl_dq = 16'h0000;
        bank_open = 2'b00;
    end

    // one command per clock, taken by the device at the following edge
    task automatic cmd(input sbc_cmd_t c, input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
        @(posedge pclk);
        q_dq = dq_out;
        q_oe = dq_oe;
        cs_n <= (c == CMD_NOP);
        {ras_n, cas_n, we_n} <= (c == CMD_ACT) ? 3'h3 : (c == CMD_READ) ? 3'h5 : (c == CMD_WRITE) ? 3'h4
            : (c == CMD_PRE) ? 3'h2 : (c == CMD_BST) ? 3'h6 : 3'h7;
        addr <= a;
        {upper_byte_mask, lower_byte_mask} <= m;
        ctl_dq <= d;
        if (c == CMD_ACT) bank_open[a[11]] = 1'b1;
        if (c == CMD_PRE) bank_open = a[10] ? 2'b00 : (bank_open & ~(2'b01 << a[11]));
    endtask

    task automatic act(input logic b);
        if (!bank_open[b]) begin
            repeat (ACT_GAP) cmd(CMD_NOP, 12'h000, 2'b00, ~ctl_dq);
            cmd(CMD_ACT, {b, 11'h000}, 2'b00, ~ctl_dq);
            repeat (ACT_GAP) cmd(CMD_NOP, 12'h000, 2'b00, ~ctl_dq);
        end
    endtask

    task automatic gate(input logic g);
        clock_gate <= g;
    endtask

endmodule // sbc_ctl_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the burst-interrupt dram core
// assumes: sbc_ctl_model on the command pins; apb slave answers with pready
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import sbc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic clock_gate, cs_n, ras_n, cas_n, we_n, upper_byte_mask, lower_byte_mask;
    logic [11:0] addr;
    logic [15:0] ctl_dq, dq_in, dq_out;
    logic [1:0] dq_oe;
    logic [15:0] mem_exp [0:511];
    int mismatches, num_checks, wseq;

    // ----------------------------------------------------------------
    // environment
    // ----------------------------------------------------------------
    // shared data wire, device lanes win while enabled
    assign dq_in = {dq_oe[1] ? dq_out[15:8] : ctl_dq[15:8], dq_oe[0] ? dq_out[7:0] : ctl_dq[7:0]};

    sbc_sdram_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_gate(clock_gate), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
        .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));

    sbc_ctl_model u_ctl (.pclk(pclk), .clock_gate(clock_gate), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .addr(addr), .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
        .ctl_dq(ctl_dq), .dq_out(dq_out), .dq_oe(dq_oe));

    // clock generation
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    // one apb transfer, waits for pready; only the watchdog ends a hang
    task automatic apb_rw(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic nop(input int k);
        repeat (k) u_ctl.cmd(CMD_NOP, 12'h000, 2'b00, ~ctl_dq);
    endtask

    // write burst; mask mv on beat mb; command sc to sa on beat sb; one: single write mode
    task automatic wr(input logic [11:0] a, input int n, input int mb, input logic [1:0] mv,
                      input sbc_cmd_t sc, input logic [11:0] sa, input int sb, input logic one);
        logic [15:0] d;
        logic [1:0] m;
        logic [8:0] idx;
        logic stop;
        stop = 1'b0;
        wseq++;
        for (int i = 0; i <= n; i++) begin
            d = (16'h1111 * i[15:0]) ^ 16'(wseq * 16'h0135);
            m = (i == mb) ? mv : 2'b00;
            if (i == sb) begin
                stop = (sc == CMD_BST) || (sa[11] == a[11]) || sa[10];
                m = (sc == CMD_PRE && stop) ? 2'b11 : m;
            end
            u_ctl.cmd(i == sb ? sc : (i == 0 ? CMD_WRITE : CMD_NOP), i == sb ? sa : a, m, d);
            idx = {a[11], a[7:0] + i[7:0]};
            if (i < n && !stop && !(one && i > 0)) begin
                if (!m[1]) mem_exp[idx][15:8] = d[15:8];
                if (!m[0]) mem_exp[idx][7:0] = d[7:0];
            end
        end
    endtask

    // read n words at cas latency cl; stop at call sb; mask mv at call mb
    task automatic rd(input logic [11:0] a, input int n, input int cl, input int sb, input int mb,
                      input logic [1:0] mv);
        int ne;
        logic [1:0] oe;
        logic [15:0] lm;
        logic [8:0] idx;
        ne = (sb < n) ? sb : n;
        u_ctl.cmd(CMD_READ, a, 2'b00, ~ctl_dq);
        for (int j = 1; j <= ne + cl + 2; j++) begin
            u_ctl.cmd(j == sb ? CMD_BST : CMD_NOP, a, j == mb ? mv : 2'b00, ~ctl_dq);
            if (j >= 1 + cl && j < 1 + cl + ne) begin
                idx = {a[11], a[7:0] + 8'(j - 1 - cl)};
                oe = (j == mb + 3) ? ~mv : 2'b11;
                lm = {{8{oe[1]}}, {8{oe[0]}}};
                chk("read lane enable", 32'(oe), 32'(u_ctl.q_oe));
                chk("read data", 32'(mem_exp[idx] & lm), 32'(u_ctl.q_dq & lm));
            end
            else if (j == 1 + cl + ne) chk("lanes released", 32'h0, 32'(u_ctl.q_oe));
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    // watchdog well beyond the roughly 800 clocks the tests need
    initial begin
        #100000;
        mismatches++;
        $display("test watchdog expired");
        end_sim();
    end

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata} = 64'h0;
        {mismatches, num_checks, wseq} = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb_rw(1'b0, 32'(SBC_CTRL_OFS), 32'h0);
        chk("ctrl reset", 32'(SBC_CTRL_RESET), rdv);
        apb_rw(1'b0, 32'(SBC_STAT_OFS), 32'h0);
        chk("status reset", 32'h0, rdv);
        apb_rw(1'b0, 32'h0000_0008, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb_rw(1'b1, 32'(SBC_STAT_OFS), 32'h1f);
        chk("status write error", 32'h1, 32'(err));
        apb_rw(1'b1, 32'(SBC_CTRL_OFS), 32'h08);
        apb_rw(1'b0, 32'(SBC_CTRL_OFS), 32'h0);
        chk("ctrl readback", 32'h08, rdv);
        $display("test registers done");
        u_ctl.act(1'b0);
        u_ctl.act(1'b1);
        u_ctl.cmd(CMD_PRE, 12'h800, 2'b11, ~ctl_dq);
        nop(1);
        apb_rw(1'b0, 32'(SBC_STAT_OFS), 32'h0);
        chk("one bank closed", 32'h1, rdv & 32'h3);
        u_ctl.act(1'b1);
        u_ctl.cmd(CMD_PRE, 12'h400, 2'b11, ~ctl_dq);
        nop(1);
        apb_rw(1'b0, 32'(SBC_STAT_OFS), 32'h0);
        chk("all banks closed", 32'h0, rdv & 32'h3);
        $display("test bank select done");
        u_ctl.act(1'b0);
        u_ctl.act(1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(12'(k * 4), 4, -1, 2'b00, CMD_NOP, 12'h000, 99, 1'b0);
            wr(12'(12'h800 + k * 4), 4, -1, 2'b00, CMD_NOP, 12'h000, 99, 1'b0);
        end
        wr(12'h000, 4, -1, 2'b00, CMD_PRE, 12'h000, 4, 1'b0);
        u_ctl.act(1'b0);
        wr(12'h000, 4, -1, 2'b00, CMD_PRE, 12'h000, 2, 1'b0);
        u_ctl.act(1'b0);
        wr(12'h800, 4, -1, 2'b00, CMD_PRE, 12'h000, 2, 1'b0);
        u_ctl.act(1'b0);
        wr(12'h004, 4, -1, 2'b00, CMD_PRE, 12'hc00, 1, 1'b0);
        u_ctl.act(1'b0);
        u_ctl.act(1'b1);
        wr(12'h804, 4, 1, 2'b10, CMD_NOP, 12'h000, 99, 1'b0);
        wr(12'h804, 4, 2, 2'b01, CMD_NOP, 12'h000, 99, 1'b0);
        apb_rw(1'b1, 32'(SBC_CTRL_OFS), 32'h18);
        wr(12'h008, 4, -1, 2'b00, CMD_NOP, 12'h000, 99, 1'b1);
        apb_rw(1'b1, 32'(SBC_CTRL_OFS), 32'h08);
        for (int k = 0; k < 4; k++) begin
            rd(12'(k * 4), 4, 2, 99, -1, 2'b00);
            rd(12'(12'h800 + k * 4), 4, 2, 99, 1, 2'b01);
        end
        $display("test write interruption done");
        u_ctl.cmd(CMD_WRITE, 12'h00c, 2'b00, 16'ha001);
        u_ctl.cmd(CMD_NOP, 12'h00c, 2'b00, 16'ha002);
        u_ctl.gate(1'b0);
        u_ctl.cmd(CMD_PRE, 12'h00c, 2'b00, 16'hdead);
        u_ctl.gate(1'b1);
        u_ctl.cmd(CMD_NOP, 12'h00c, 2'b00, 16'ha003);
        u_ctl.cmd(CMD_NOP, 12'h00c, 2'b00, 16'ha004);
        nop(2);
        for (int k = 0; k < 4; k++) mem_exp[12 + k] = 16'ha001 + 16'(k);
        rd(12'h00c, 4, 2, 99, -1, 2'b00);
        $display("test clock suspend done");
        apb_rw(1'b1, 32'(SBC_CTRL_OFS), 32'h03);
        wr(12'h010, 258, 256, 2'b11, CMD_BST, 12'h010, 258, 1'b0);
        rd(12'h010, 260, 3, 260, 100, 2'b11);
        apb_rw(1'b1, 32'(SBC_CTRL_OFS), 32'h02);
        rd(12'h010, 300, 2, 5, -1, 2'b00);
        u_ctl.cmd(CMD_PRE, 12'h400, 2'b11, ~ctl_dq);
        nop(1);
        $display("test full page done");
        end_sim();
    end

endmodule // tb_top
`default_nettype wire
